// ### dpch_offset_pkg.sv
package dpch_offset_pkg;
	localparam int FRAME_BITS = 8;
	localparam int CHIP_BITS = 16;
	localparam int TOTAL_BITS = 24;
	localparam int BOUNDARY_BITS = 16;
	localparam logic [15:0] CHIPS_PER_FRAME = 16'h9600;
	localparam logic [15:0] CHIP_OFFSET_MAX = 16'h95ff;
	localparam logic [23:0] WRAP_CHIPS = 24'h960000;
	localparam logic [7:0] ROUND_HALF = 8'h80;
	localparam logic [9:0] FDD_DEFAULT_MAX = 10'h257;
	localparam logic [2:0] TDD_DEFAULT_MAX = 3'h7;
	localparam logic [15:0] REPORTED_CHIP_MAX = 16'h95ff;
	localparam logic [7:0] RESET_FRAME = 8'h00;
	localparam logic [15:0] RESET_CHIP = 16'h0000;
	localparam logic [23:0] RESET_TIMING = 24'h000000;

	typedef struct packed {
		logic [7:0] frameOffset;
		logic [15:0] chipOffset;
	} link_offset_t;

	typedef struct packed {
		logic [23:0] chipDelay;
		logic [15:0] boundary;
		logic rangeError;
	} dpch_timing_t;
endpackage

// ### offset_rounder.sv
`timescale 1ns/1ns
module offset_rounder (
	input wire logic [7:0] frameOffset,
	input wire logic [15:0] chipOffset,
	output logic [23:0] roundedChips
);
	logic [23:0] combined;
	logic [23:0] floorChips;
	logic [24:0] ceilChips;
	logic roundUp;
	logic aligned;

	// 255 * 38400 + 65535 still fits 24 bits, so nothing is lost in the product
	assign combined = ({16'h0000, frameOffset} * {8'h00, dpch_offset_pkg::CHIPS_PER_FRAME})
		+ {8'h00, chipOffset};
	assign aligned = (combined[7:0] == 8'h00);
	assign roundUp = (combined[7:0] >= dpch_offset_pkg::ROUND_HALF);
	assign floorChips = {combined[23:8], 8'h00};
	assign ceilChips = {1'b0, floorChips} + 25'h0000100;
	// rounding up past frame 255 wraps modulo 256 frames; the result is zero for any chip offset up to 0x95ff
	assign roundedChips = aligned ? combined :
		!roundUp ? floorChips :
		(ceilChips >= {1'b0, dpch_offset_pkg::WRAP_CHIPS}) ?
		ceilChips[23:0] - dpch_offset_pkg::WRAP_CHIPS : ceilChips[23:0];
endmodule

// ### dpch_timing_offset.sv
`timescale 1ns/1ns
module dpch_timing_offset (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic frameLoad,
	input wire logic [7:0] frameOffset,
	input wire logic chipLoad,
	input wire logic [15:0] chipOffset,
	input wire logic frameStart,
	input wire logic [7:0] cellFrameNumber,
	output logic timingValid,
	output dpch_offset_pkg::dpch_timing_t timing,
	output logic txStart
);
	dpch_offset_pkg::link_offset_t held_reg;
	logic frameSeen_reg;
	logic chipSeen_reg;
	logic timingValid_reg;
	dpch_offset_pkg::dpch_timing_t timing_reg;
	logic [23:0] chipCount_reg;
	logic [23:0] chipCount_next;
	logic txStart_reg;
	logic chipBad_reg;

	dpch_offset_pkg::link_offset_t loaded;
	logic [23:0] rounded;
	logic bothLoaded;
	logic chipBad;
	logic hitTarget;
	logic frameZero;
	logic [23:0] wrapFrom;

	// range test shared by the flag and its check
	function automatic logic chipOutOfRange(input logic [15:0] chip);
		return chip > dpch_offset_pkg::CHIP_OFFSET_MAX;
	endfunction

	assign loaded.frameOffset = frameLoad ? frameOffset : held_reg.frameOffset;
	assign loaded.chipOffset = chipLoad ? chipOffset : held_reg.chipOffset;
	// out-of-range chip offsets are flagged, not corrected; the controller owns the value
	assign chipBad = chipLoad ? chipOutOfRange(chipOffset) : chipBad_reg;
	assign bothLoaded = (frameSeen_reg | frameLoad) & (chipSeen_reg | chipLoad) & (frameLoad | chipLoad);

	offset_rounder u_offset_rounder (
		.frameOffset(loaded.frameOffset),
		.chipOffset(loaded.chipOffset),
		.roundedChips(rounded)
	);

	// chip counter runs from the common control channel frame 0 of the 256-frame cycle
	assign frameZero = frameStart && cellFrameNumber == 8'h00;
	assign chipCount_next = frameZero ? 24'h000000 :
		(chipCount_reg == dpch_offset_pkg::WRAP_CHIPS - 24'h000001) ? 24'h000000 :
		chipCount_reg + 24'h000001;
	assign hitTarget = timing_reg.rangeError == 1'b0 && frameSeen_reg && chipSeen_reg
		&& chipCount_reg == timing_reg.chipDelay;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			held_reg <= {dpch_offset_pkg::RESET_FRAME, dpch_offset_pkg::RESET_CHIP};
			frameSeen_reg <= 1'b0;
			chipSeen_reg <= 1'b0;
			chipBad_reg <= 1'b0;
		end else begin
			held_reg <= loaded;
			frameSeen_reg <= frameSeen_reg | frameLoad;
			chipSeen_reg <= chipSeen_reg | chipLoad;
			chipBad_reg <= chipBad;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			timingValid_reg <= 1'b0;
			timing_reg <= {dpch_offset_pkg::RESET_TIMING, 16'h0000, 1'b0};
		end else begin
			timingValid_reg <= bothLoaded;
			if (bothLoaded) begin
				timing_reg <= {rounded, rounded[23:8], chipBad};
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			chipCount_reg <= dpch_offset_pkg::RESET_TIMING;
			txStart_reg <= 1'b0;
		end else begin
			chipCount_reg <= chipCount_next;
			txStart_reg <= hitTarget;
		end
	end

	assign timingValid = timingValid_reg;
	assign timing = timing_reg;
	assign txStart = txStart_reg;

	// valid handshake
	AST_VALID_PULSE: assert property (@(posedge mclk) disable iff (!resetn)
		timingValid |-> ##1 (!timingValid || $past(bothLoaded)))
		else $error("valid without a load");

	AST_VALID_AFTER_LOAD: assert property (@(posedge mclk) disable iff (!resetn)
		bothLoaded |=> timingValid)
		else $error("valid missing after load");

	AST_NO_VALID_IDLE: assert property (@(posedge mclk) disable iff (!resetn)
		!bothLoaded |=> !timingValid)
		else $error("valid without a completing load");

	AST_NO_VALID_BEFORE_FRAME: assert property (@(posedge mclk) disable iff (!resetn)
		(!frameSeen_reg && !frameLoad) |=> !timingValid)
		else $error("valid before any frame offset");

	AST_NO_VALID_BEFORE_CHIP: assert property (@(posedge mclk) disable iff (!resetn)
		(!chipSeen_reg && !chipLoad) |=> !timingValid)
		else $error("valid before any chip offset");

	// rounding and result shape
	// first combined value whose round-up passes frame 255
	assign wrapFrom = dpch_offset_pkg::WRAP_CHIPS - 24'(dpch_offset_pkg::ROUND_HALF);

	AST_ALIGNED: assert property (@(posedge mclk) disable iff (!resetn)
		timingValid |-> timing.chipDelay[7:0] == 8'h00)
		else $error("result not on 256-chip boundary");

	AST_BOUNDARY: assert property (@(posedge mclk) disable iff (!resetn)
		timingValid |-> timing.boundary == timing.chipDelay[23:8])
		else $error("boundary count does not match delay");

	AST_IN_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
		(timingValid && !timing.rangeError) |-> timing.chipDelay < dpch_offset_pkg::WRAP_CHIPS)
		else $error("result beyond 256 frames");

	AST_ROUND_DOWN: assert property (@(posedge mclk) disable iff (!resetn)
		(bothLoaded && u_offset_rounder.combined[7:0] != 8'h00
		&& !u_offset_rounder.combined[7])
		|=> timing.chipDelay == {$past(u_offset_rounder.combined[23:8]), 8'h00})
		else $error("round down wrong");

	AST_ROUND_UP: assert property (@(posedge mclk) disable iff (!resetn)
		(bothLoaded && u_offset_rounder.combined[7]
		&& u_offset_rounder.combined < wrapFrom)
		|=> timing.chipDelay == {$past(u_offset_rounder.combined[23:8]) + 16'h0001, 8'h00})
		else $error("round up wrong");

	AST_ROUND_WRAP: assert property (@(posedge mclk) disable iff (!resetn)
		(bothLoaded && !chipBad && u_offset_rounder.combined >= wrapFrom)
		|=> timing.chipDelay == 24'h000000)
		else $error("round up past frame 255 did not wrap");

	AST_KEEP_ALIGNED: assert property (@(posedge mclk) disable iff (!resetn)
		(bothLoaded && u_offset_rounder.combined[7:0] == 8'h00)
		|=> timing.chipDelay == $past(u_offset_rounder.combined))
		else $error("aligned value changed");

	// range flag and load capture
	AST_CHIP_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
		(bothLoaded && chipLoad && chipOutOfRange(chipOffset)) |=> (timingValid && timing.rangeError))
		else $error("out-of-range chip offset not flagged");

	AST_CHIP_CLEAN: assert property (@(posedge mclk) disable iff (!resetn)
		(bothLoaded && !chipBad) |=> !timing.rangeError)
		else $error("legal chip offset flagged");

	AST_FRAME_HELD: assert property (@(posedge mclk) disable iff (!resetn)
		frameLoad |=> held_reg.frameOffset == $past(frameOffset))
		else $error("frame offset not captured");

	AST_CHIP_HELD: assert property (@(posedge mclk) disable iff (!resetn)
		chipLoad |=> held_reg.chipOffset == $past(chipOffset))
		else $error("chip offset not captured");

	AST_TIMING_HOLDS: assert property (@(posedge mclk) disable iff (!resetn)
		!bothLoaded |=> $stable(timing))
		else $error("result changed without a load");

	// chip counter and transmit start
	AST_COUNT_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
		frameZero |=> chipCount_reg == 24'h000000)
		else $error("counter not restarted at frame 0");

	// sampled reset keeps the release edge, where the counter still sits at zero, out
	AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (!resetn)
		(resetn && !frameZero && chipCount_reg != dpch_offset_pkg::WRAP_CHIPS - 24'h000001)
		|=> chipCount_reg == $past(chipCount_reg) + 24'h000001)
		else $error("counter skipped a chip");

	AST_COUNT_RANGE: assert property (@(posedge mclk) disable iff (!resetn)
		chipCount_reg < dpch_offset_pkg::WRAP_CHIPS)
		else $error("counter beyond 256 frames");

	AST_TX_AT_TARGET: assert property (@(posedge mclk) disable iff (!resetn)
		txStart |-> $past(chipCount_reg) == $past(timing.chipDelay))
		else $error("transmit start off target");

	AST_TX_SUPPRESSED: assert property (@(posedge mclk) disable iff (!resetn)
		txStart |-> !$past(timing.rangeError))
		else $error("transmit start with flagged offset");

	AST_TX_NEEDS_BOTH: assert property (@(posedge mclk) disable iff (!resetn)
		txStart |-> ($past(frameSeen_reg) && $past(chipSeen_reg)))
		else $error("transmit start before both offsets");
endmodule

// ### ctrl_model.sv
`timescale 1ns/1ns
module ctrl_model (
	input wire logic mclk,
	output logic frameLoad,
	output logic [7:0] frameOffset,
	output logic chipLoad,
	output logic [15:0] chipOffset
);
	initial begin
		frameLoad = 1'b0;
		chipLoad = 1'b0;
		frameOffset = 8'h00;
		chipOffset = 16'h0000;
	end
	// stand-in for an unmeasurable frame difference; value is arbitrary
	localparam logic [7:0] SUBST_FRAME_DIFF = 8'h00;
	// defaults belong to the link that enters the dedicated state, never to later ones
	logic dedicated = 1'b0;
	// offsets are worked out here, the device only consumes them
	task automatic send(input logic fl, input logic cl, input logic [7:0] f, input logic [15:0] c);
		@(posedge mclk);
		frameLoad <= fl;
		chipLoad <= cl;
		frameOffset <= f;
		chipOffset <= c;
		@(posedge mclk);
		frameLoad <= 1'b0;
		chipLoad <= 1'b0;
		// released data is scrambled so a stale value is never relied on
		frameOffset <= ~f;
		chipOffset <= ~c;
	endtask
	task automatic setup_fdd(input logic [9:0] dflt);
		logic [9:0] d;
		int chips;
		d = (dflt > dpch_offset_pkg::FDD_DEFAULT_MAX) ? dpch_offset_pkg::FDD_DEFAULT_MAX : dflt;
		chips = int'(d) * 512;
		if (!dedicated) begin
			dedicated = 1'b1;
			send(1'b1, 1'b1, 8'(chips / int'(dpch_offset_pkg::CHIPS_PER_FRAME)),
				16'(chips % int'(dpch_offset_pkg::CHIPS_PER_FRAME)));
		end
	endtask
	task automatic setup_tdd(input logic [2:0] dflt);
		if (!dedicated) begin
			dedicated = 1'b1;
			send(1'b1, 1'b1, {5'h00, dflt}, 16'h0000);
		end
	endtask
	// differences are taken against whichever reference cell the terminal picked
	task automatic add_link(input logic [7:0] frameDiff, input logic measured,
		input logic [15:0] chipDiff);
		logic [7:0] f;
		logic [15:0] c;
		f = measured ? frameDiff : SUBST_FRAME_DIFF;
		c = (chipDiff > dpch_offset_pkg::REPORTED_CHIP_MAX) ?
			dpch_offset_pkg::REPORTED_CHIP_MAX : chipDiff;
		if (dedicated) begin
			send(1'b1, 1'b1, f, c);
		end
	endtask
	task automatic leave;
		dedicated = 1'b0;
	endtask
endmodule

// ### dpch_timing_offset_tb.sv
`timescale 1ns/1ns
module dpch_timing_offset_tb;
	logic mclk, resetn, frameStart, timingValid, txStart, frameLoad, chipLoad;
	logic [7:0] frameOffset, cellFrameNumber;
	logic [15:0] chipOffset;
	dpch_offset_pkg::dpch_timing_t timing;
	int miscompares = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [7:0] fs[7] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'hff, 8'hff, 8'h03};
	logic [15:0] cs[7] = '{16'h007f, 16'h0000, 16'h0100, 16'h95ff, 16'h9580, 16'h957f, 16'h95ff};
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	ctrl_model u_ctrl_model (.mclk(mclk), .frameLoad(frameLoad), .frameOffset(frameOffset),
		.chipLoad(chipLoad), .chipOffset(chipOffset));
	dpch_timing_offset u_dpch_timing_offset (.mclk(mclk), .resetn(resetn), .frameLoad(frameLoad),
		.frameOffset(frameOffset), .chipLoad(chipLoad), .chipOffset(chipOffset),
		.frameStart(frameStart), .cellFrameNumber(cellFrameNumber), .timingValid(timingValid),
		.timing(timing), .txStart(txStart));
	task automatic chk(input string what, input logic [23:0] expv, input logic [23:0] got);
		checksDone++;
		if (got !== expv) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, expv, got);
		end
	endtask
	function automatic logic [23:0] rounded(input logic [7:0] f, input logic [15:0] c);
		int comb;
		comb = f * 38400 + c;
		comb = (comb % 256 >= 128) ? comb - comb % 256 + 256 : comb - comb % 256;
		return (comb >= 9830400) ? 24'h000000 : 24'(comb);
	endfunction
	task automatic test_first;
		u_ctrl_model.send(1'b1, 1'b0, 8'h01, 16'h0000);
		#1 chk("valid early", 24'h0, 24'(timingValid));
		u_ctrl_model.send(1'b0, 1'b1, 8'h00, 16'h0080);
		#1 chk("valid", 24'h1, 24'(timingValid));
		chk("chipDelay", 24'h009700, timing.chipDelay);
		@(posedge mclk);
		#1 chk("valid width", 24'h0, 24'(timingValid));
		$display("test_first done");
	endtask
	task automatic test_round;
		for (int i = 0; i < 7; i++) begin
			u_ctrl_model.send(1'b1, 1'b1, fs[i], cs[i]);
			#1 chk("valid", 24'h1, 24'(timingValid));
			chk("chipDelay", rounded(fs[i], cs[i]), timing.chipDelay);
			chk("boundary", rounded(fs[i], cs[i]) >> 8, 24'(timing.boundary));
			chk("rangeError", 24'h0, 24'(timing.rangeError));
		end
		$display("test_round done");
	endtask
	task automatic test_tx;
		int n;
		u_ctrl_model.send(1'b1, 1'b1, 8'h00, 16'h0100);
		frameStart <= 1'b1;
		cellFrameNumber <= 8'h00;
		@(posedge mclk);
		frameStart <= 1'b0;
		cellFrameNumber <= 8'h05;
		n = 1;
		#1;
		while (txStart !== 1'b1 && n < 400) begin
			@(posedge mclk);
			#1 n++;
		end
		// counter restarts one edge after frameStart and txStart is registered: 256 + 2
		chk("txStart delay", 24'h000102, 24'(n));
		@(posedge mclk);
		#1 chk("txStart width", 24'h0, 24'(txStart));
		$display("test_tx done");
	endtask
	task automatic test_range;
		u_ctrl_model.send(1'b0, 1'b1, 8'h00, 16'h9600);
		#1 chk("valid", 24'h1, 24'(timingValid));
		chk("rangeError", 24'h1, 24'(timing.rangeError));
		$display("test_range done");
	endtask
	task automatic test_setup;
		u_ctrl_model.setup_fdd(10'h257);
		#1 chk("fdd chipDelay", 24'h04ae00, timing.chipDelay);
		u_ctrl_model.add_link(8'h02, 1'b1, 16'h0081);
		#1 chk("link chipDelay", 24'h012d00, timing.chipDelay);
		u_ctrl_model.add_link(8'h04, 1'b0, 16'h0000);
		#1 chk("substitute", rounded(u_ctrl_model.SUBST_FRAME_DIFF, 16'h0000), timing.chipDelay);
		u_ctrl_model.leave();
		u_ctrl_model.setup_tdd(3'h7);
		#1 chk("tdd chipDelay", 24'h041a00, timing.chipDelay);
		$display("test_setup done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			conclude();
		end
	end
	initial begin
		resetn = 1'b0;
		frameStart = 1'b0;
		cellFrameNumber = 8'h00;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		test_first();
		test_round();
		test_tx();
		test_range();
		test_setup();
		conclude();
	end
endmodule
